// ### cie_instruction_engine.sv
// Operation
// [R1] Error codes FFFF none, FFFD invalid, FFFC read queue busy, FFFA write.
// [R2] Error codes FFFB not initialized, FFF9 table full, FFF8 queue full.
// [R3] Interrupt enable bits 0..7 map to the eight listed events.
// [R4] Interrupt output only for events whose enable bit is set.
// [R5] Host loads I/O registers, then writes the opcode.
// [R6] Host waits for flag bit 10 before the next instruction.
// [R7] Opcodes 0000/000F insert, 0001/000E delete.
// [R8] 0006 check, 000B initialize, 0004 fast mode, 0005 buffered mode.
// [R9] 0008 ATM, 0003 count, 0002/000D mask, 0007, 0009, 000A recognized.
// [R10] Operand is I/O 3 down to I/O 0, I/O 3 bit 15 is MSB.
// [R11] Buffered insert goes to first free queue slot, matchable at once.
// [R12] Buffered insert with full queue: nothing stored, FFF8, error, irq 0.
// [R13] Fast insert writes straight into the table.
// [R14] Fast insert with full table: nothing stored, FFF9, error, irq 1.
// [R15] Buffered insert of an existing pattern replaces that entry.
// [R16] Host never inserts duplicate patterns in fast mode.
// [R17] Delete compares unmasked bits and invalidates the matching entry.
// [R18] Check hit sets match flag and copies entry into I/O registers.
// [R19] Check miss clears match flag; completion raises irq bit 2.
// [R20] Check completes within 8 clock cycles.
// [R21] Matching refused until initialize table runs after fast loading.
// [R22] Initialize done sets initialized and buffered flags, irq bit 3.
// [R23] Registers read-only during initialize, up to 80 ms.
// [R24] Opcode write clears error flag and sets error code to FFFF.
// [R25] Flag bits: 7 error, 1 match, 2 initialized, 3 buffered mode.
// [R26] Mask bit 0 compares the bit, mask bit 1 ignores it.
// [R27] Unknown opcode: invalid code, error flag, irq bit 7.
`timescale 1ns/1ps
`default_nettype none
module cie_instruction_engine #(
  parameter int unsigned INIT_CYCLES = cie_pkg::INIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ctlSelN,
  input  wire logic        ctlWriteN,
  input  wire logic [2:0]  ctlAddr,
  input  wire logic [15:0] dqIn,
  output var  logic [15:0] dqOut,
  output var  logic        dqOeN,
  output var  logic        dtackOut,
  output var  logic        dtackOeN,
  output var  logic        irqOut,
  output var  logic        irqOeN
);
  localparam int unsigned DW    = cie_pkg::DATA_W;
  localparam int unsigned KW    = cie_pkg::KEY_W;
  localparam int unsigned EW    = cie_pkg::EVT_W;
  localparam int unsigned PW    = cie_pkg::POINT_W;
  localparam int unsigned SYNCW = 2 + 3 + DW;

  cie_table_if tbl ();
  cie_cam_table u_table (
    .clk   (clk),
    .rst_n (rst_n),
    .tbl   (tbl.store)
  );

  logic [SYNCW-1:0]       pinMeta_r;
  logic [SYNCW-1:0]       pinSync_r;
  logic                   ack_r;
  logic                   readAck_r;
  logic [DW-1:0]          dqOut_r;
  logic [DW-1:0]          io_r [4];
  logic [DW-1:0]          opcode_r;
  logic [DW-1:0]          errCode_r;
  logic [DW-1:0]          intEn_r;
  logic [KW-1:0]          mask_r;
  logic [PW-1:0]          almostPoint_r;
  logic [cie_pkg::CNT_W-1:0] prevCount_r;
  logic [31:0]            initCnt_r;
  logic                   matchOk_r, tableInit_r, bufMode_r, error_r;
  logic                   almostFull_r, atmMode_r, opDone_r, irqPend_r;
  cie_pkg::cie_state_type state_r, state_nxt;
  cie_pkg::cie_cmd_type   cmdKind;
  logic [DW-1:0]          errNxt;
  logic [EW-1:0]          evt;
  logic [DW-1:0]          flagWord;
  logic [DW-1:0]          readData;
  logic                   initDone, almostHit;

  // Pins come from the host's domain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinMeta_r <= '1;
      pinSync_r <= '1;
    end else begin
      pinMeta_r <= {ctlSelN, ctlWriteN, ctlAddr, dqIn};
      pinSync_r <= pinMeta_r;
    end
  end

  wire            selN    = pinSync_r[SYNCW-1];
  wire            isWrite = !pinSync_r[SYNCW-2];
  wire [2:0]      addr    = pinSync_r[DW+2:DW];
  wire [DW-1:0]   wData   = pinSync_r[DW-1:0];
  wire            isIdle  = (state_r == cie_pkg::ST_IDLE);
  wire            newReq  = !selN && !ack_r;
  // Writes stall without acknowledge while an instruction runs
  wire            doWrite = newReq && isWrite && isIdle; // R23
  wire            doRead  = newReq && !isWrite;
  wire            opWrite = doWrite && (addr == cie_pkg::ADDR_OP); // R5
  wire            inExec  = (state_r == cie_pkg::ST_EXEC);
  wire            isCheck = inExec && (opcode_r == cie_pkg::OP_CHECK);
  wire            checkGo = isCheck && tableInit_r;
  wire [KW-1:0]   operand = {io_r[3], io_r[2], io_r[1], io_r[0]}; // R10

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_r     <= 1'b0;
      readAck_r <= 1'b0;
    end else if (selN) begin
      ack_r     <= 1'b0;
      readAck_r <= 1'b0;
    end else if (doWrite || doRead) begin
      ack_r     <= 1'b1;
      readAck_r <= doRead;
    end
  end

  always_comb begin
    flagWord                        = '0;
    flagWord[cie_pkg::FLG_INT_ON]   = |intEn_r[EW-1:0];
    flagWord[cie_pkg::FLG_MATCH]    = matchOk_r; // R25
    flagWord[cie_pkg::FLG_INIT]     = tableInit_r; // R25
    flagWord[cie_pkg::FLG_BUF_MODE] = bufMode_r; // R25
    flagWord[cie_pkg::FLG_Q_EMPTY]  = tbl.queueEmpty;
    flagWord[cie_pkg::FLG_Q_FULL]   = tbl.queueFull;
    flagWord[cie_pkg::FLG_TBL_FULL] = tbl.tableFull;
    flagWord[cie_pkg::FLG_ERROR]    = error_r; // R25
    flagWord[cie_pkg::FLG_ALMOST]   = almostFull_r;
    flagWord[cie_pkg::FLG_ATM]      = atmMode_r;
    flagWord[cie_pkg::FLG_DONE]     = opDone_r;
  end

  always_comb begin
    case (addr)
      cie_pkg::ADDR_IO0:    readData = io_r[0];
      cie_pkg::ADDR_IO1:    readData = io_r[1];
      cie_pkg::ADDR_IO2:    readData = io_r[2];
      cie_pkg::ADDR_IO3:    readData = io_r[3];
      cie_pkg::ADDR_OP:     readData = opcode_r;
      cie_pkg::ADDR_FLAG:   readData = flagWord;
      cie_pkg::ADDR_ERR:    readData = errCode_r;
      default:              readData = intEn_r;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dqOut_r <= '0;
    end else if (doRead) begin
      dqOut_r <= readData;
    end
  end

  // Decode of the pending opcode, one cycle in EXEC
  always_comb begin
    cmdKind = cie_pkg::CMD_NONE;
    errNxt  = cie_pkg::ERR_NONE;
    evt     = '0;
    if (inExec) begin
      case (opcode_r)
        cie_pkg::OP_INSERT_A, cie_pkg::OP_INSERT_B: begin // R7
          if (bufMode_r && tbl.queueFull) begin
            errNxt                 = cie_pkg::ERR_QUEUE_FULL; // R12
            evt[cie_pkg::INT_Q_FULL] = 1'b1; // R12
          end else if (!bufMode_r && tbl.tableFull) begin
            errNxt                   = cie_pkg::ERR_TBL_FULL; // R14
            evt[cie_pkg::INT_TBL_FULL] = 1'b1; // R14
          end else begin
            cmdKind = bufMode_r ? cie_pkg::CMD_INS_BUF
                                : cie_pkg::CMD_INS_FAST; // R11 R13
          end
        end
        cie_pkg::OP_DELETE_A, cie_pkg::OP_DELETE_B: begin // R7
          cmdKind = cie_pkg::CMD_DELETE; // R17
        end
        cie_pkg::OP_CHECK: begin // R8
          if (!tableInit_r) begin
            errNxt = cie_pkg::ERR_NO_INIT; // R21
          end
          evt[cie_pkg::INT_CHECK] = 1'b1; // R19
        end
        cie_pkg::OP_FAST_MODE: begin // R8
          if (!tbl.queueEmpty) begin
            errNxt                      = cie_pkg::ERR_WRITE_Q; // R1
            evt[cie_pkg::INT_FAST_FAIL] = 1'b1; // R3
          end
        end
        cie_pkg::OP_FAST_READ: begin // R9
          if (!tbl.queueEmpty) begin
            errNxt                   = cie_pkg::ERR_READ_Q; // R1
            evt[cie_pkg::INT_READ_Q] = 1'b1; // R3
          end
        end
        cie_pkg::OP_INIT, cie_pkg::OP_BUF_MODE, cie_pkg::OP_ATM,
        cie_pkg::OP_COUNT, cie_pkg::OP_MASK_A, cie_pkg::OP_MASK_B,
        cie_pkg::OP_ALMOST, cie_pkg::OP_READ_PTR: begin // R8 R9
          errNxt = cie_pkg::ERR_NONE;
        end
        default: begin
          errNxt                    = cie_pkg::ERR_INVALID; // R27
          evt[cie_pkg::INT_ILLEGAL] = 1'b1; // R27
        end
      endcase
    end
    evt[cie_pkg::INT_INIT]   = initDone; // R22
    evt[cie_pkg::INT_ALMOST] = almostHit;
  end

  assign tbl.cmd     = cmdKind;
  assign tbl.operand = operand;
  assign tbl.mask    = mask_r;

  assign initDone  = (state_r == cie_pkg::ST_INIT) &&
                     (initCnt_r == 32'(INIT_CYCLES - 1)); // R23
  // Only table growth counts, queued entries do not
  assign almostHit = (tbl.tableCount > prevCount_r) &&
                     (tbl.tableCount ==
                      cie_pkg::CNT_W'(almostPoint_r));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cie_pkg::ST_IDLE: if (opWrite) state_nxt = cie_pkg::ST_EXEC;
      cie_pkg::ST_EXEC: begin
        state_nxt = (opcode_r == cie_pkg::OP_INIT) ? cie_pkg::ST_INIT
                                                   : cie_pkg::ST_IDLE;
      end
      cie_pkg::ST_INIT: if (initDone) state_nxt = cie_pkg::ST_IDLE;
      default:          state_nxt = cie_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r   <= cie_pkg::ST_IDLE;
      initCnt_r <= '0;
    end else begin
      state_r   <= state_nxt;
      initCnt_r <= (state_r == cie_pkg::ST_INIT) ? initCnt_r + 32'h1 : '0;
    end
  end

  // I/O registers: host writes, check result, entry count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) io_r[i] <= '0;
    end else if (doWrite && !addr[2]) begin
      io_r[addr[1:0]] <= wData; // R5
    end else if (checkGo && tbl.hit) begin
      io_r[0] <= tbl.hitData[DW-1:0]; // R18
      io_r[1] <= tbl.hitData[2*DW-1:DW];
      io_r[2] <= tbl.hitData[3*DW-1:2*DW];
      io_r[3] <= tbl.hitData[4*DW-1:3*DW];
    end else if (inExec && opcode_r == cie_pkg::OP_COUNT) begin
      io_r[0] <= DW'(tbl.entryCount);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opcode_r <= cie_pkg::OPCODE_RESET;
      intEn_r  <= cie_pkg::INT_EN_RESET;
    end else if (doWrite && addr == cie_pkg::ADDR_OP) begin
      opcode_r <= wData;
    end else if (doWrite && addr == cie_pkg::ADDR_INT_EN) begin
      intEn_r  <= wData; // R3
    end
  end

  // Error state; opcode write and error report never share a cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      errCode_r <= cie_pkg::ERR_NONE;
      error_r   <= 1'b0;
    end else if (opWrite) begin
      errCode_r <= cie_pkg::ERR_NONE; // R24
      error_r   <= 1'b0; // R24
    end else if (errNxt != cie_pkg::ERR_NONE) begin
      errCode_r <= errNxt; // R1 R2
      error_r   <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      matchOk_r <= 1'b0;
    end else if (checkGo) begin
      matchOk_r <= tbl.hit; // R18 R19
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tableInit_r <= 1'b1;
      bufMode_r   <= 1'b1;
      atmMode_r   <= 1'b0;
    end else if (initDone) begin
      tableInit_r <= 1'b1; // R22
      bufMode_r   <= 1'b1; // R22
    end else if (inExec) begin
      if (opcode_r == cie_pkg::OP_FAST_MODE && tbl.queueEmpty) begin
        bufMode_r   <= 1'b0;
        tableInit_r <= 1'b0;
      end else if (opcode_r == cie_pkg::OP_BUF_MODE) begin
        bufMode_r <= 1'b1;
      end else if (opcode_r == cie_pkg::OP_ATM) begin
        atmMode_r <= 1'b1;
      end
      if (cmdKind == cie_pkg::CMD_INS_FAST) begin
        tableInit_r <= 1'b0; // R21
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_r        <= '0;
      almostPoint_r <= '0;
      almostFull_r  <= 1'b0;
      prevCount_r   <= '0;
    end else begin
      prevCount_r <= tbl.tableCount;
      if (inExec && (opcode_r == cie_pkg::OP_MASK_A ||
                     opcode_r == cie_pkg::OP_MASK_B)) begin
        mask_r <= operand; // R26
      end
      if (almostHit) begin
        almostFull_r <= 1'b1;
      end else if (inExec && opcode_r == cie_pkg::OP_ALMOST) begin
        almostPoint_r <= io_r[0][PW-1:0];
        almostFull_r  <= 1'b0;
      end
    end
  end

  // Done flag drops with the opcode write, rises when back in IDLE
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opDone_r <= 1'b1;
    end else if (opWrite) begin
      opDone_r <= 1'b0;
    end else if (state_nxt == cie_pkg::ST_IDLE && !isIdle) begin
      opDone_r <= 1'b1; // R6 R20
    end
  end

  // New event wins over the clear by an opcode write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqPend_r <= 1'b0;
    end else if (|(evt & intEn_r[EW-1:0])) begin
      irqPend_r <= 1'b1; // R4
    end else if (opWrite) begin
      irqPend_r <= 1'b0;
    end
  end

  assign dqOut    = dqOut_r;
  assign dqOeN    = !readAck_r;
  assign dtackOut = 1'b0;
  assign dtackOeN = !ack_r;
  assign irqOut   = 1'b0;
  assign irqOeN   = !irqPend_r;
endmodule // cie_instruction_engine
`default_nettype wire

// ### cie_pkg.sv
`default_nettype none
package cie_pkg;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned KEY_W       = 64;
  localparam int unsigned TABLE_DEPTH = 16384;
  localparam int unsigned QUEUE_DEPTH = 14;
  localparam int unsigned CNT_W = $clog2(TABLE_DEPTH + QUEUE_DEPTH + 1);
  localparam int unsigned POINT_W     = 14;
  localparam int unsigned EVT_W       = 8;

  // Control port register offsets
  localparam logic [2:0] ADDR_IO0    = 3'h0;
  localparam logic [2:0] ADDR_IO1    = 3'h1;
  localparam logic [2:0] ADDR_IO2    = 3'h2;
  localparam logic [2:0] ADDR_IO3    = 3'h3;
  localparam logic [2:0] ADDR_OP     = 3'h4;
  localparam logic [2:0] ADDR_FLAG   = 3'h5;
  localparam logic [2:0] ADDR_ERR    = 3'h6;
  localparam logic [2:0] ADDR_INT_EN = 3'h7;

  // Operation codes
  localparam logic [15:0] OP_INSERT_A  = 16'h0000;
  localparam logic [15:0] OP_INSERT_B  = 16'h000F;
  localparam logic [15:0] OP_DELETE_A  = 16'h0001;
  localparam logic [15:0] OP_DELETE_B  = 16'h000E;
  localparam logic [15:0] OP_MASK_A    = 16'h0002;
  localparam logic [15:0] OP_MASK_B    = 16'h000D;
  localparam logic [15:0] OP_COUNT     = 16'h0003;
  localparam logic [15:0] OP_FAST_MODE = 16'h0004;
  localparam logic [15:0] OP_BUF_MODE  = 16'h0005;
  localparam logic [15:0] OP_CHECK     = 16'h0006;
  localparam logic [15:0] OP_ALMOST    = 16'h0007;
  localparam logic [15:0] OP_ATM       = 16'h0008;
  localparam logic [15:0] OP_READ_PTR  = 16'h0009;
  localparam logic [15:0] OP_FAST_READ = 16'h000A;
  localparam logic [15:0] OP_INIT      = 16'h000B;

  // Error codes
  localparam logic [15:0] ERR_NONE      = 16'hFFFF;
  localparam logic [15:0] ERR_INVALID   = 16'hFFFD;
  localparam logic [15:0] ERR_READ_Q    = 16'hFFFC;
  localparam logic [15:0] ERR_NO_INIT   = 16'hFFFB;
  localparam logic [15:0] ERR_WRITE_Q   = 16'hFFFA;
  localparam logic [15:0] ERR_TBL_FULL  = 16'hFFF9;
  localparam logic [15:0] ERR_QUEUE_FULL = 16'hFFF8;

  // Flag register bit positions
  localparam int unsigned FLG_INT_ON    = 0;
  localparam int unsigned FLG_MATCH     = 1;
  localparam int unsigned FLG_INIT      = 2;
  localparam int unsigned FLG_BUF_MODE  = 3;
  localparam int unsigned FLG_Q_EMPTY   = 4;
  localparam int unsigned FLG_Q_FULL    = 5;
  localparam int unsigned FLG_TBL_FULL  = 6;
  localparam int unsigned FLG_ERROR     = 7;
  localparam int unsigned FLG_ALMOST    = 8;
  localparam int unsigned FLG_ATM       = 9;
  localparam int unsigned FLG_DONE      = 10;

  // Interrupt enable bit positions
  localparam int unsigned INT_Q_FULL    = 0;
  localparam int unsigned INT_TBL_FULL  = 1;
  localparam int unsigned INT_CHECK     = 2;
  localparam int unsigned INT_INIT      = 3;
  localparam int unsigned INT_FAST_FAIL = 4;
  localparam int unsigned INT_ALMOST    = 5;
  localparam int unsigned INT_READ_Q    = 6;
  localparam int unsigned INT_ILLEGAL   = 7;

  localparam logic [15:0] INT_EN_RESET  = 16'h0000;
  localparam logic [15:0] OPCODE_RESET  = 16'h0000;

  // Initialize-table busy time
  localparam int unsigned CLK_HZ       = 25000000;
  localparam int unsigned INIT_TIME_MS = 80;
  localparam int unsigned INIT_CYCLES  = INIT_TIME_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    CMD_NONE     = 2'h0,
    CMD_INS_BUF  = 2'h1,
    CMD_INS_FAST = 2'h2,
    CMD_DELETE   = 2'h3
  } cie_cmd_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_INIT = 3'h4
  } cie_state_type;
endpackage
`default_nettype wire

// ### cie_table_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cie_table_if;
  cie_pkg::cie_cmd_type              cmd;
  logic [cie_pkg::KEY_W-1:0]         operand;
  logic [cie_pkg::KEY_W-1:0]         mask;
  logic                              hit;
  logic [cie_pkg::KEY_W-1:0]         hitData;
  logic                              queueEmpty;
  logic                              queueFull;
  logic                              tableFull;
  logic [cie_pkg::CNT_W-1:0]         tableCount;
  logic [cie_pkg::CNT_W-1:0]         entryCount;

  modport eng (output cmd, output operand, output mask, input hit,
               input hitData, input queueEmpty, input queueFull,
               input tableFull, input tableCount, input entryCount);
  modport store (input cmd, input operand, input mask, output hit,
                 output hitData, output queueEmpty, output queueFull,
                 output tableFull, output tableCount, output entryCount);
endinterface
`default_nettype wire

// ### cie_cam_table.sv
`timescale 1ns/1ps
`default_nettype none
module cie_cam_table #(
  parameter int unsigned DEPTH  = cie_pkg::TABLE_DEPTH,
  parameter int unsigned QDEPTH = cie_pkg::QUEUE_DEPTH
) (
  input wire logic    clk,
  input wire logic    rst_n,
  cie_table_if.store  tbl
);
  localparam int unsigned KW = cie_pkg::KEY_W;
  localparam int unsigned CW = cie_pkg::CNT_W;

  logic [KW-1:0]     entry_r [DEPTH];
  logic [DEPTH-1:0]  valid_r;
  logic [KW-1:0]     qEntry_r [QDEPTH];
  logic [QDEPTH-1:0] qValid_r;
  logic [CW-1:0]     tblCount_r;
  logic [DEPTH-1:0]  tHit;
  logic [QDEPTH-1:0] qHit;
  logic              tAny, qAny, freeAny, qFreeAny, qOldAny;
  int unsigned       tIdx, qIdx, freeIdx, qFreeIdx, qOldIdx;
  logic [CW-1:0]     qCount;

  // Masked compare: a 1 in the mask drops the bit from the compare
  for (genvar g = 0; g < DEPTH; g++) begin : g_tcmp
    assign tHit[g] = valid_r[g] &&
                     (((entry_r[g] ^ tbl.operand) & ~tbl.mask) == '0); // R26
  end
  for (genvar g = 0; g < QDEPTH; g++) begin : g_qcmp
    assign qHit[g] = qValid_r[g] &&
                     (((qEntry_r[g] ^ tbl.operand) & ~tbl.mask) == '0);
  end

  always_comb begin
    tAny = 1'b0; tIdx = 0; freeAny = 1'b0; freeIdx = 0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (tHit[i]) begin
        tAny = 1'b1;
        tIdx = i;
      end
      if (!valid_r[i]) begin
        freeAny = 1'b1;
        freeIdx = i;
      end
    end
  end

  always_comb begin
    qAny = 1'b0; qIdx = 0; qFreeAny = 1'b0; qFreeIdx = 0;
    qOldAny = 1'b0; qOldIdx = 0; qCount = '0;
    for (int i = QDEPTH - 1; i >= 0; i--) begin
      if (qHit[i]) begin
        qAny = 1'b1;
        qIdx = i;
      end
      if (!qValid_r[i]) begin
        qFreeAny = 1'b1;
        qFreeIdx = i;
      end else begin
        qOldAny = 1'b1;
        qOldIdx = i;
        qCount  = CW'(qCount + 1'b1);
      end
    end
  end

  // Queue copy wins over the table copy of the same pattern
  assign tbl.hit        = tAny || qAny;
  assign tbl.hitData    = qAny ? qEntry_r[qIdx] : entry_r[tIdx];
  assign tbl.queueEmpty = (qValid_r == '0);
  assign tbl.queueFull  = !qFreeAny;
  assign tbl.tableFull  = !freeAny;
  assign tbl.tableCount = tblCount_r;
  assign tbl.entryCount = CW'(tblCount_r + qCount);

  // Drain moves one queued entry per idle cycle into a free table slot
  wire drain = (tbl.cmd == cie_pkg::CMD_NONE) && qOldAny && freeAny;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid_r    <= '0;
      qValid_r   <= '0;
      tblCount_r <= '0;
    end else begin
      case (tbl.cmd)
        cie_pkg::CMD_INS_BUF: begin
          if (qAny) begin
            qEntry_r[qIdx] <= tbl.operand; // R15
          end else if (tAny) begin
            entry_r[tIdx] <= tbl.operand; // R15
          end else begin
            qEntry_r[qFreeIdx] <= tbl.operand; // R11
            qValid_r[qFreeIdx] <= 1'b1;
          end
        end
        cie_pkg::CMD_INS_FAST: begin
          entry_r[freeIdx] <= tbl.operand; // R13
          valid_r[freeIdx] <= 1'b1;
          tblCount_r       <= CW'(tblCount_r + 1'b1);
        end
        cie_pkg::CMD_DELETE: begin
          if (qAny) begin
            qValid_r[qIdx] <= 1'b0; // R17
          end else if (tAny) begin
            valid_r[tIdx] <= 1'b0; // R17
            tblCount_r    <= CW'(tblCount_r - 1'b1);
          end
        end
        default: begin
          if (drain) begin
            entry_r[freeIdx]   <= qEntry_r[qOldIdx];
            valid_r[freeIdx]   <= 1'b1;
            qValid_r[qOldIdx]  <= 1'b0;
            tblCount_r         <= CW'(tblCount_r + 1'b1);
          end
        end
      endcase
    end
  end
endmodule // cie_cam_table
`default_nettype wire

// ### cie_engine_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cie_engine_sva #(
  parameter int unsigned INIT_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ctlSelN,
  input wire logic        ctlWriteN,
  input wire logic [2:0]  ctlAddr,
  input wire logic [15:0] dqOut,
  input wire logic        dqOeN,
  input wire logic        dtackOut,
  input wire logic        dtackOeN,
  input wire logic        irqOut,
  input wire logic        irqOeN
);
  // Writes stall for the whole table build
  localparam int WMAX = INIT_CYCLES + 40;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_ack_a: assert property ($fell(ctlSelN) && ctlWriteN && dtackOeN
    |-> ##[2:4] !dtackOeN) else $error("read ack late");
  wr_stall_a: assert property ($fell(ctlSelN) && !ctlWriteN && dtackOeN
    |-> ##[2:WMAX] !dtackOeN) else $error("write ack missing");
  ack_hold_a: assert property (!dtackOeN && !ctlSelN
    |=> !dtackOeN) else $error("ack dropped early");
  dq_ack_a: assert property (!dqOeN |-> !dtackOeN && ctlWriteN)
    else $error("data driven without read ack");
  ack_release_a: assert property ($rose(ctlSelN)
    |-> ##[1:4] dtackOeN && dqOeN) else $error("ack not released");
  reset_idle_a: assert property ($rose(rst_n)
    |-> dqOeN && dtackOeN && irqOeN) else $error("pins busy after reset");
  dtack_od_a: assert property (dtackOut == 1'b0) else $error("dtack level");
  irq_od_a: assert property (irqOut == 1'b0) else $error("irq level");
  irq_clear_a: assert property ($rose(irqOeN) && $past(rst_n)
    |-> !ctlSelN && !ctlWriteN && ctlAddr == cie_pkg::ADDR_OP)
    else $error("irq cleared without opcode write");
endmodule // cie_engine_sva
bind cie_instruction_engine cie_engine_sva #(.INIT_CYCLES(INIT_CYCLES)) sva (
  .clk(clk), .rst_n(rst_n), .ctlSelN(ctlSelN), .ctlWriteN(ctlWriteN),
  .ctlAddr(ctlAddr), .dqOut(dqOut), .dqOeN(dqOeN), .dtackOut(dtackOut),
  .dtackOeN(dtackOeN), .irqOut(irqOut), .irqOeN(irqOeN));
`default_nettype wire

// ### cie_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cie_host_model (
  input  wire logic        clk,
  output var  logic        ctlSelN,
  output var  logic        ctlWriteN,
  output var  logic [2:0]  ctlAddr,
  output var  logic [15:0] dqIn,
  input  wire logic [15:0] dqOut,
  input  wire logic        dtackOeN
);
  initial begin
    ctlSelN = 1'b1;
    ctlWriteN = 1'b1;
    ctlAddr = 3'h0;
    dqIn = 16'hA5C3;
  end
  // Qualifiers held until the ack edge; next access waits for ack release
  task automatic acc(input logic w, input logic [2:0] a,
                     input logic [15:0] d, output logic [15:0] q,
                     output int n);
    @(posedge clk);
    #1 ctlSelN = 1'b0;
    ctlWriteN = ~w;
    ctlAddr = a;
    dqIn = w ? d : dqIn;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (dtackOeN !== 1'b0 && n < 200);
    q = dqOut;
    #1 ctlSelN = 1'b1;
    dqIn = ~dqIn;
    for (int i = 0; i < 8 && dtackOeN !== 1'b1; i++) @(posedge clk);
    if (n >= 200 || dtackOeN !== 1'b1)
      cam_control_instruction_engine_tb.end_of_test(1'b1);
  endtask
endmodule // cie_host_model
`default_nettype wire

// ### cam_control_instruction_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cam_control_instruction_engine_tb;
  localparam int unsigned INIT = 20;
  localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
  // Expected irqOeN, opcode, expected error code
  localparam logic [32:0] ROWS [12] = '{33'h0_0010_FFFD, 33'h1_0003_FFFF,
    33'h1_0005_FFFF, 33'h0_0006_FFFF, 33'h1_0002_FFFF, 33'h1_000D_FFFF,
    33'h1_0007_FFFF, 33'h1_0009_FFFF, 33'h1_000A_FFFF, 33'h1_0001_FFFF,
    33'h1_0008_FFFF, 33'h0_000C_FFFD};
  localparam logic [18:0] RST [3] = '{19'h6_FFFF, 19'h7_0000, 19'h5_041C};
  logic        clk, rst_n, ctlSelN, ctlWriteN, dqOeN;
  logic        dtackOut, dtackOeN, irqOut, irqOeN;
  logic [2:0]  ctlAddr;
  logic [15:0] dqIn, dqOut, q;
  int          n, n_mismatch, total_checks;
  cie_instruction_engine #(.INIT_CYCLES(INIT)) uut (
    .clk(clk), .rst_n(rst_n), .ctlSelN(ctlSelN), .ctlWriteN(ctlWriteN),
    .ctlAddr(ctlAddr), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN),
    .dtackOut(dtackOut), .dtackOeN(dtackOeN), .irqOut(irqOut),
    .irqOeN(irqOeN));
  cie_host_model host (.clk(clk), .ctlSelN(ctlSelN), .ctlWriteN(ctlWriteN),
    .ctlAddr(ctlAddr), .dqIn(dqIn), .dqOut(dqOut), .dtackOeN(dtackOeN));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_of_test(input logic hang);
    if (hang) n_mismatch++;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    host.acc(1'b1, a, d, q, n);
  endtask
  task automatic rd(input logic [2:0] a);
    host.acc(1'b0, a, 16'h0000, q, n);
  endtask
  task automatic done_err(input logic [15:0] e);
    q = 16'h0000;
    for (int i = 0; i < 40 && q[10] !== 1'b1; i++) rd(cie_pkg::ADDR_FLAG);
    if (q[10] !== 1'b1) end_of_test(1'b1);
    rd(cie_pkg::ADDR_ERR);
    chk("error code", q, e);
  endtask
  task automatic op(input logic [15:0] c, e);
    wr(cie_pkg::ADDR_OP, c);
    done_err(e);
  endtask
  task automatic irq(input logic e);
    chk("irqOeN", {15'h0000, irqOeN}, {15'h0000, e});
  endtask
  initial begin
    rst_n = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    wr(cie_pkg::ADDR_INT_EN, 16'h00FF);
    rd(cie_pkg::ADDR_INT_EN);
    chk("interrupt_enable", q, 16'h00FF);
    foreach (ROWS[i]) begin
      op(ROWS[i][31:16], ROWS[i][15:0]);
      irq(ROWS[i][32]);
    end
    $display("opcode table done");
    #1 rst_n = 1'b0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    foreach (RST[i]) begin
      rd(RST[i][18:16]);
      chk("reset value", q, RST[i][15:0]);
    end
    $display("reset test done");
    wr(cie_pkg::ADDR_INT_EN, 16'h000C);
    op(16'h0010, 16'hFFFD);
    irq(1'b1);
    wr(cie_pkg::ADDR_IO0, 16'hFFFF);
    op(16'h0002, 16'hFFFF);
    for (int i = 0; i < 4; i++) wr(3'(i), KEY[16*i +: 16]);
    op(16'h0000, 16'hFFFF);
    wr(cie_pkg::ADDR_IO0, 16'h0000);
    op(16'h0006, 16'hFFFF);
    irq(1'b0);
    rd(cie_pkg::ADDR_FLAG);
    chk("match flag", q & 16'h0002, 16'h0002);
    rd(cie_pkg::ADDR_IO0);
    chk("io0", q, KEY[15:0]);
    rd(cie_pkg::ADDR_IO3);
    chk("io3", q, KEY[63:48]);
    op(16'h000E, 16'hFFFF);
    op(16'h0006, 16'hFFFF);
    rd(cie_pkg::ADDR_FLAG);
    chk("miss flag", q & 16'h0002, 16'h0000);
    op(16'h0004, 16'hFFFF);
    rd(cie_pkg::ADDR_FLAG);
    chk("fast flags", q & 16'h000C, 16'h0000);
    op(16'h0000, 16'hFFFF);
    op(16'h0006, 16'hFFFB);
    wr(cie_pkg::ADDR_OP, 16'h000B);
    wr(cie_pkg::ADDR_IO0, 16'h1234);
    chk("write stall", {15'h0000, n > 10}, 16'h0001);
    done_err(16'hFFFF);
    rd(cie_pkg::ADDR_FLAG);
    chk("init flags", q & 16'h000C, 16'h000C);
    irq(1'b0);
    $display("entry test done");
    end_of_test(1'b0);
  end
endmodule // cam_control_instruction_engine_tb
`default_nettype wire
